// ### logic/floppy_selftest_pkg.sv
// Constants and types shared by the drive self-test and status logic
package floppy_selftest_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_KHZ = 125000;
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned STEP_MS = 3;
   localparam int unsigned STEP_CYC = STEP_MS * CLK_KHZ;
   localparam int unsigned STEP_PULSE_NS = 1000;
   localparam int unsigned STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned INDEX_WAIT_MS = 500;
   localparam int unsigned INDEX_WAIT_CYC = INDEX_WAIT_MS * CLK_KHZ;
   localparam int unsigned FLASH_ON_MS = 250;
   localparam int unsigned FLASH_ON_CYC = FLASH_ON_MS * CLK_KHZ;
   localparam int unsigned FLASH_OFF_MS = 250;
   localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CLK_KHZ;
   localparam int unsigned FLASH_GAP_MS = 1000;
   localparam int unsigned FLASH_GAP_CYC = FLASH_GAP_MS * CLK_KHZ;
   // ==========================================================
   // Widths and counts
   localparam int unsigned TMR_W = 27;
   localparam int unsigned CNT_W = 7;
   localparam int unsigned PCNT_W = 8;
   localparam int unsigned PIN_W = 16;
   localparam logic [CNT_W-1:0] SEEK_MAX = 7'h50;
   localparam logic [CNT_W-1:0] IN_STEPS = 7'h04;
   localparam logic [CNT_W-1:0] OUT_MAX = 7'h06;
   // ==========================================================
   // Flash codes: first group, then the second group per failure
   localparam int unsigned CODE_W = 3;
   localparam logic [CODE_W-1:0] CODE_FIRST = 3'h3;
   localparam logic [CODE_W-1:0] CODE_STEP_IN = 3'h2;
   localparam logic [CODE_W-1:0] CODE_STEP_OUT = 3'h3;
   localparam logic [CODE_W-1:0] CODE_INDEX = 3'h4;
   localparam logic [CODE_W-1:0] CODE_NONE = 3'h0;
   // ==========================================================
   // States
   typedef enum logic [2:0] {
      ST_SEEK0, ST_STEP_IN, ST_STEP_OUT, ST_READY, ST_IDX_WAIT, ST_ERROR, ST_ERR_DONE
   } selftest_state_type;
   typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF} flash_state_type;
endpackage

// ### logic/flash_if.sv
// Link between the self-test sequencer and the flash code generator
`timescale 1ns/10ps
interface flash_if;
   logic run;
   logic [2:0] second_cnt;
   logic led;
   logic cycle_done;
   modport gen (input run, input second_cnt, output led, output cycle_done);
   modport ctl (output run, output second_cnt, input led, input cycle_done);
endinterface

// ### logic/flash_code_gen.sv
// Indicator flash code generator: two pulse groups and a long dark gap
`timescale 1ns/10ps
module flash_code_gen #(
   parameter int unsigned ON_CYC_P = floppy_selftest_pkg::FLASH_ON_CYC,
   parameter int unsigned OFF_CYC_P = floppy_selftest_pkg::FLASH_OFF_CYC,
   parameter int unsigned GAP_CYC_P = floppy_selftest_pkg::FLASH_GAP_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Sequencer side
   flash_if.gen fl
);
   import floppy_selftest_pkg::*;

   flash_state_type fst_ff;
   logic [TMR_W-1:0] ftmr_ff;
   logic [CODE_W-1:0] left_ff;
   logic group_ff;
   logic led_ff;
   logic done_ff;
   logic ftmr_zero;

   assign ftmr_zero = (ftmr_ff == '0);
   assign fl.led = led_ff;
   assign fl.cycle_done = done_ff;

   // ==========================================================
   // Pulse sequencer
   // RQ15 two groups, long gap
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fst_ff <= FL_IDLE;
         ftmr_ff <= '0;
         left_ff <= '0;
         group_ff <= 1'b0;
         led_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (!ftmr_zero) begin
            ftmr_ff <= ftmr_ff - 1'b1;
         end
         case (fst_ff)
            FL_IDLE: begin
               if (fl.run) begin
                  fst_ff <= FL_ON;
                  led_ff <= 1'b1;
                  ftmr_ff <= TMR_W'(ON_CYC_P - 1);
                  group_ff <= 1'b0;
                  left_ff <= CODE_FIRST - 1'b1;
               end
            end
            FL_ON: begin
               if (ftmr_zero) begin
                  fst_ff <= FL_OFF;
                  led_ff <= 1'b0;
                  ftmr_ff <= (left_ff == '0) ? TMR_W'(GAP_CYC_P - 1) : TMR_W'(OFF_CYC_P - 1);
               end
            end
            FL_OFF: begin
               if (ftmr_zero) begin
                  if (left_ff != '0) begin
                     left_ff <= left_ff - 1'b1;
                     fst_ff <= FL_ON;
                     led_ff <= 1'b1;
                     ftmr_ff <= TMR_W'(ON_CYC_P - 1);
                  end else if (!group_ff) begin
                     group_ff <= 1'b1;
                     left_ff <= fl.second_cnt - 1'b1;
                     fst_ff <= FL_ON;
                     led_ff <= 1'b1;
                     ftmr_ff <= TMR_W'(ON_CYC_P - 1);
                  end else begin
                     // Restart keeps the code repeating while the sequencer holds run
                     done_ff <= 1'b1;
                     group_ff <= 1'b0;
                     left_ff <= CODE_FIRST - 1'b1;
                     fst_ff <= fl.run ? FL_ON : FL_IDLE;
                     led_ff <= fl.run;
                     ftmr_ff <= TMR_W'(ON_CYC_P - 1);
                  end
               end
            end
            default: fst_ff <= FL_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Checks
   logic led_prev_ff;
   logic [3:0] pulses_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         led_prev_ff <= 1'b0;
         pulses_ff <= '0;
      end else begin
         led_prev_ff <= led_ff;
         pulses_ff <= (done_ff ? 4'h0 : pulses_ff) + {3'h0, led_ff & ~led_prev_ff};
      end
   end

   flash_count_a: assert property ( // RQ15
      @(posedge clk_i) disable iff (!rst_n_i)
      done_ff |-> pulses_ff == 4'(CODE_FIRST) + 4'(fl.second_cnt))
      else $error("flash cycle pulse count wrong");
   flash_dark_a: assert property ( // RQ15
      @(posedge clk_i) disable iff (!rst_n_i)
      (fst_ff == FL_ON && ftmr_zero) |=> !led_ff && fst_ff == FL_OFF)
      else $error("flash pulse not ended");
   flash_cycle_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) done_ff);
endmodule

// ### logic/floppy_drive_selftest_status.sv
// Drive supervisory logic: power-on tests, index check, flash codes, status
// Operation
// RQ1 - Write protected diskette blocks writes, flags status
// RQ2 - Indicator lights while this unit is selected
// RQ3 - Respond only to own select of four
// RQ4 - Power-on: step in, then step out
// RQ5 - Step-in failure flashes three then two
// RQ6 - Step-out failure flashes three then three
// RQ7 - Lever closure starts index pulse check
// RQ8 - Missing index pulse flashes three then four
// RQ9 - Failed test reruns after lever open-close
// RQ10 - Error cycle completes only with lever open
// RQ11 - Head loaded exactly while lever latched
// RQ12 - Report one- or two-sided diskette status
// RQ13 - Raw read data, no clock separation
// RQ14 - Host spaces step requests three milliseconds apart
// RQ15 - Two pulse groups, long gap, repeating
`timescale 1ns/10ps
module floppy_drive_selftest_status #(
   parameter int unsigned STEP_CYC_P = floppy_selftest_pkg::STEP_CYC,
   parameter int unsigned INDEX_WAIT_CYC_P = floppy_selftest_pkg::INDEX_WAIT_CYC,
   parameter int unsigned FLASH_ON_CYC_P = floppy_selftest_pkg::FLASH_ON_CYC,
   parameter int unsigned FLASH_OFF_CYC_P = floppy_selftest_pkg::FLASH_OFF_CYC,
   parameter int unsigned FLASH_GAP_CYC_P = floppy_selftest_pkg::FLASH_GAP_CYC
) (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // Host requests
   input wire logic [3:0] SELECT_I,
   input wire logic [1:0] UNIT_ADDR_I,
   input wire logic WRITE_GATE_I,
   input wire logic WRITE_DATA_I,
   input wire logic STEP_I,
   input wire logic DIR_IN_I,
   // Drive sensors
   input wire logic WP_SENSE_I,
   input wire logic TRK0_SENSE_I,
   input wire logic INDEX0_SENSE_I,
   input wire logic INDEX1_SENSE_I,
   input wire logic LEVER_CLOSED_I,
   input wire logic RAW_READ_I,
   // Host status
   output logic WRITE_PROT_O,
   output logic TWO_SIDED_O,
   output logic TRACK0_O,
   output logic INDEX_O,
   output logic READ_DATA_O,
   // Mechanism and panel
   output logic HEAD_LOAD_O,
   output logic WRITE_EN_O,
   output logic WRITE_DATA_O,
   output logic STEP_O,
   output logic STEP_DIR_IN_O,
   output logic LED_O
);
   import floppy_selftest_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] sync1_ff;
   logic [PIN_W-1:0] sync2_ff;
   logic [3:0] sel_s;
   logic [1:0] addr_s;
   logic wgate_s, wdata_s, step_s, dir_s, wp_s, trk0_s, idx0_s, idx1_s, lever_s, rdata_s;

   assign pin_raw = {SELECT_I, UNIT_ADDR_I, WRITE_GATE_I, WRITE_DATA_I, STEP_I, DIR_IN_I,
                     WP_SENSE_I, TRK0_SENSE_I, INDEX0_SENSE_I, INDEX1_SENSE_I,
                     LEVER_CLOSED_I, RAW_READ_I};
   assign {sel_s, addr_s, wgate_s, wdata_s, step_s, dir_s, wp_s, trk0_s, idx0_s, idx1_s,
           lever_s, rdata_s} = sync2_ff;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
      end
   end

   // ==========================================================
   // Edges and selection
   logic idx0_prev_ff, idx1_prev_ff, lever_prev_ff;
   logic idx0_rise, idx1_rise, lever_rise, sel;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         idx0_prev_ff <= 1'b0;
         idx1_prev_ff <= 1'b0;
         lever_prev_ff <= 1'b0;
      end else begin
         idx0_prev_ff <= idx0_s;
         idx1_prev_ff <= idx1_s;
         lever_prev_ff <= lever_s;
      end
   end

   assign idx0_rise = idx0_s & ~idx0_prev_ff;
   assign idx1_rise = idx1_s & ~idx1_prev_ff;
   assign lever_rise = lever_s & ~lever_prev_ff;
   // RQ3 own select decode
   assign sel = sel_s[addr_s];

   // ==========================================================
   // Self-test sequencer
   flash_if fl();
   selftest_state_type st_ff;
   logic [TMR_W-1:0] tmr_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [CODE_W-1:0] code_ff;
   logic tmr_zero, issue_out, issue_in, carriage_test, host_ok;

   assign tmr_zero = (tmr_ff == '0);
   assign issue_out = tmr_zero && !trk0_s &&
                      ((st_ff == ST_SEEK0 && cnt_ff != SEEK_MAX) ||
                       (st_ff == ST_STEP_OUT && cnt_ff != OUT_MAX));
   assign issue_in = tmr_zero && st_ff == ST_STEP_IN && cnt_ff != IN_STEPS;
   assign carriage_test = (st_ff == ST_SEEK0) || (st_ff == ST_STEP_IN) ||
                          (st_ff == ST_STEP_OUT);
   assign host_ok = (st_ff == ST_READY) || (st_ff == ST_IDX_WAIT);

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_ff <= ST_SEEK0;
         tmr_ff <= TMR_W'(STEP_CYC_P - 1);
         cnt_ff <= '0;
         code_ff <= CODE_NONE;
      end else begin
         if (!tmr_zero) begin
            tmr_ff <= tmr_ff - 1'b1;
         end
         if (issue_out || issue_in) begin
            tmr_ff <= TMR_W'(STEP_CYC_P - 1);
            cnt_ff <= cnt_ff + 1'b1;
         end
         case (st_ff)
            // RQ4 seek home before test
            ST_SEEK0: begin
               if (tmr_zero && trk0_s) begin
                  st_ff <= ST_STEP_IN;
                  cnt_ff <= '0;
               end else if (tmr_zero && cnt_ff == SEEK_MAX) begin
                  // RQ5 sensor stuck at zero
                  st_ff <= ST_ERROR;
                  code_ff <= CODE_STEP_IN;
               end
            end
            ST_STEP_IN: begin
               if (tmr_zero && cnt_ff == IN_STEPS) begin
                  cnt_ff <= '0;
                  tmr_ff <= TMR_W'(STEP_CYC_P - 1);
                  // RQ5 still on track zero
                  if (trk0_s) begin
                     st_ff <= ST_ERROR;
                     code_ff <= CODE_STEP_IN;
                  end else begin
                     st_ff <= ST_STEP_OUT;
                  end
               end
            end
            ST_STEP_OUT: begin
               if (tmr_zero && trk0_s) begin
                  // RQ7 lever already closed at start
                  st_ff <= lever_s ? ST_IDX_WAIT : ST_READY;
                  tmr_ff <= TMR_W'(INDEX_WAIT_CYC_P - 1);
                  code_ff <= CODE_NONE;
               end else if (tmr_zero && cnt_ff == OUT_MAX) begin
                  // RQ6 track zero never reached
                  st_ff <= ST_ERROR;
                  code_ff <= CODE_STEP_OUT;
               end
            end
            ST_READY: begin
               // RQ7 closure starts index check
               if (lever_rise) begin
                  st_ff <= ST_IDX_WAIT;
                  tmr_ff <= TMR_W'(INDEX_WAIT_CYC_P - 1);
               end
            end
            ST_IDX_WAIT: begin
               if (!lever_s || idx0_rise) begin
                  st_ff <= ST_READY;
               end else if (tmr_zero) begin
                  // RQ8 no index pulse
                  st_ff <= ST_ERROR;
                  code_ff <= CODE_INDEX;
               end
            end
            ST_ERROR: begin
               // RQ10 finish only with lever open
               if (!lever_s && fl.cycle_done) begin
                  st_ff <= ST_ERR_DONE;
               end
            end
            ST_ERR_DONE: begin
               // RQ9 rerun after open then close
               if (lever_s) begin
                  cnt_ff <= '0;
                  if (code_ff == CODE_INDEX) begin
                     st_ff <= ST_IDX_WAIT;
                     tmr_ff <= TMR_W'(INDEX_WAIT_CYC_P - 1);
                  end else begin
                     st_ff <= ST_SEEK0;
                     tmr_ff <= TMR_W'(STEP_CYC_P - 1);
                  end
               end
            end
            default: st_ff <= ST_SEEK0;
         endcase
      end
   end

   // ==========================================================
   // Own step pulses
   logic [PCNT_W-1:0] pcnt_ff;
   logic own_dir_ff;
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pcnt_ff <= '0;
         own_dir_ff <= 1'b0;
      end else if (issue_out || issue_in) begin
         pcnt_ff <= PCNT_W'(STEP_PULSE_CYC);
         own_dir_ff <= issue_in;
      end else if (pcnt_ff != '0) begin
         pcnt_ff <= pcnt_ff - 1'b1;
      end
   end

   // ==========================================================
   // Diskette sides
   logic two_sided_ff;
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         two_sided_ff <= 1'b0;
      end else if (!lever_s) begin
         two_sided_ff <= 1'b0;
      end else if (idx1_rise) begin
         // RQ12 second index hole seen
         two_sided_ff <= 1'b1;
      end
   end

   // ==========================================================
   // Flash code generator
   assign fl.run = (st_ff == ST_ERROR);
   assign fl.second_cnt = code_ff;

   flash_code_gen #(
      .ON_CYC_P(FLASH_ON_CYC_P),
      .OFF_CYC_P(FLASH_OFF_CYC_P),
      .GAP_CYC_P(FLASH_GAP_CYC_P)
   ) u_flash (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .fl(fl.gen)
   );

   // ==========================================================
   // Registered outputs
   logic nxt_write_en;
   // RQ1 write gating
   assign nxt_write_en = sel & wgate_s & ~wp_s & host_ok;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         WRITE_PROT_O <= 1'b0;
         TWO_SIDED_O <= 1'b0;
         TRACK0_O <= 1'b0;
         INDEX_O <= 1'b0;
         READ_DATA_O <= 1'b0;
         WRITE_EN_O <= 1'b0;
         WRITE_DATA_O <= 1'b0;
      end else begin
         // RQ3 status only when selected
         WRITE_PROT_O <= sel & wp_s;
         TWO_SIDED_O <= sel & two_sided_ff;
         TRACK0_O <= sel & trk0_s;
         INDEX_O <= sel & idx0_s;
         // RQ13 raw digitised data
         READ_DATA_O <= sel & rdata_s;
         WRITE_EN_O <= nxt_write_en;
         WRITE_DATA_O <= nxt_write_en & wdata_s;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         HEAD_LOAD_O <= 1'b0;
         STEP_O <= 1'b0;
         STEP_DIR_IN_O <= 1'b0;
         LED_O <= 1'b0;
      end else begin
         // RQ11 head follows lever
         HEAD_LOAD_O <= lever_s;
         // RQ14 host paces its own steps
         STEP_O <= carriage_test ? (pcnt_ff != '0) : (sel & step_s & host_ok);
         STEP_DIR_IN_O <= carriage_test ? own_dir_ff : dir_s;
         // RQ2 select lamp, flash on error
         LED_O <= (st_ff == ST_ERROR) ? fl.led : sel;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   wp_block_a: assert property (wp_s |=> !WRITE_EN_O && !WRITE_DATA_O) // RQ1
      else $error("write enabled while protected");
   wp_status_a: assert property (sel && wp_s |=> WRITE_PROT_O) // RQ1
      else $error("protect status missing");
   led_select_a: assert property (st_ff != ST_ERROR && sel |=> LED_O) // RQ2
      else $error("indicator dark while selected");
   unit_gate_a: assert property (!sel |=> !INDEX_O && !TRACK0_O && !READ_DATA_O) // RQ3
      else $error("output while not selected");
   test_order_a: assert property ($rose(st_ff == ST_STEP_OUT) |-> // RQ4
      $past(st_ff) == ST_STEP_IN) else $error("step out before step in");
   stepin_code_a: assert property (st_ff == ST_STEP_IN && tmr_zero && // RQ5
      cnt_ff == IN_STEPS && trk0_s |=> st_ff == ST_ERROR && code_ff == CODE_STEP_IN)
      else $error("step-in failure code wrong");
   stepout_code_a: assert property (st_ff == ST_STEP_OUT && tmr_zero && // RQ6
      cnt_ff == OUT_MAX && !trk0_s |=> st_ff == ST_ERROR && code_ff == CODE_STEP_OUT)
      else $error("step-out failure code wrong");
   index_start_a: assert property (st_ff == ST_READY && lever_rise |=> // RQ7
      st_ff == ST_IDX_WAIT) else $error("index check not started");
   index_code_a: assert property (st_ff == ST_IDX_WAIT && lever_s && !idx0_rise && // RQ8
      tmr_zero |=> st_ff == ST_ERROR && code_ff == CODE_INDEX)
      else $error("index failure code wrong");
   rerun_hold_a: assert property (st_ff == ST_ERROR |=> // RQ9
      st_ff == ST_ERROR || st_ff == ST_ERR_DONE) else $error("test rerun too early");
   err_done_a: assert property ($rose(st_ff == ST_ERR_DONE) |-> !$past(lever_s)) // RQ10
      else $error("error cycle ended with lever closed");
   head_load_a: assert property (lever_s ##1 lever_s |-> HEAD_LOAD_O) // RQ11
      else $error("head not loaded");
   head_unload_a: assert property (!lever_s |=> !HEAD_LOAD_O) // RQ11
      else $error("head loaded with lever open");
   sides_out_a: assert property (sel && two_sided_ff |=> TWO_SIDED_O) // RQ12
      else $error("two-sided status missing");
   raw_data_a: assert property (sel |=> READ_DATA_O == $past(rdata_s)) // RQ13
      else $error("read data not raw");

   index_pass_c: cover property (st_ff == ST_IDX_WAIT ##1 st_ff == ST_READY);
   stepin_fail_c: cover property (st_ff == ST_ERROR && code_ff == CODE_STEP_IN);
   err_done_c: cover property ($rose(st_ff == ST_ERR_DONE));
   host_step_c: cover property (host_ok && sel && step_s);
endmodule

// ### verification/host_ctrl_model.sv
// Host controller model: unit select, write and step requests
`timescale 1ns/10ps
module host_ctrl_model #(
   parameter int unsigned GAP_P = 40
) (
   // Clock
   input wire logic clk_i,
   // Requests
   output logic [3:0] select_o,
   output logic gate_o,
   output logic data_o,
   output logic step_o,
   output logic dir_o
);
   initial begin
      select_o = 4'h0;
      gate_o = 1'b0;
      data_o = 1'b0;
      step_o = 1'b0;
      dir_o = 1'b0;
   end
   // ==========================================
   // select, write gate, write data and direction, set on the next clock edge
   task automatic drive(input logic [3:0] s, input logic g, input logic d, input logic dr);
      @(posedge clk_i);
      select_o <= s;
      gate_o <= g;
      data_o <= d;
      dir_o <= dr;
   endtask
   // ==========================================
   // step spacing kept by the host
   task automatic seek_step(input logic dr);
      @(posedge clk_i);
      dir_o <= dr;
      step_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      step_o <= 1'b0;
      repeat (GAP_P) @(posedge clk_i);
   endtask
endmodule

// ### verification/floppy_drive_selftest_status_bench.sv
// Bench: carriage model, host model and self-checking sequence
`timescale 1ns/10ps
module floppy_drive_selftest_status_bench;
   import floppy_selftest_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, wp, t0, i0, i1, lev, raw, sto_q;
   logic [1:0] addr;
   logic [3:0] sel;
   logic gate, wd, st, dir;
   logic wpo, two, t0o, ixo, rdo, hl, we, wdo, sto, sdir, led;
   int err_total = 0, checks_done = 0, cyc = 0, trk = 0, maxtrk = 0, mode = 0, a, b;
   logic [31:0] r = 32'h15CDE0F9;
   always #4 clk = ~clk;
   host_ctrl_model #(.GAP_P(40)) u_host_ctrl_model (.clk_i(clk), .select_o(sel),
      .gate_o(gate), .data_o(wd), .step_o(st), .dir_o(dir));
   floppy_drive_selftest_status #(.STEP_CYC_P(200), .INDEX_WAIT_CYC_P(400), .FLASH_ON_CYC_P(4),
      .FLASH_OFF_CYC_P(4), .FLASH_GAP_CYC_P(12)) u_floppy_drive_selftest_status (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .SELECT_I(sel), .UNIT_ADDR_I(addr),
      .WRITE_GATE_I(gate), .WRITE_DATA_I(wd), .STEP_I(st), .DIR_IN_I(dir), .WP_SENSE_I(wp),
      .TRK0_SENSE_I(t0), .INDEX0_SENSE_I(i0), .INDEX1_SENSE_I(i1), .LEVER_CLOSED_I(lev),
      .RAW_READ_I(raw), .WRITE_PROT_O(wpo), .TWO_SIDED_O(two), .TRACK0_O(t0o), .INDEX_O(ixo),
      .READ_DATA_O(rdo), .HEAD_LOAD_O(hl), .WRITE_EN_O(we), .WRITE_DATA_O(wdo), .STEP_O(sto),
      .STEP_DIR_IN_O(sdir), .LED_O(led));
   // ==========================================
   // Carriage: mode 1 sensor stuck 0, 2 no outward motion, 3 sensor stuck 1
   // Step and direction are sampled on the clock, so both outputs have settled
   always @(posedge clk) begin
      sto_q <= sto;
      if (sto === 1'b1 && sto_q === 1'b0) begin
         if (sdir) begin
            trk <= trk + 1;
            if (trk + 1 > maxtrk) maxtrk <= trk + 1;
         end else if (mode != 2 && trk > 0) begin
            trk <= trk - 1;
         end
      end
   end
   always @(posedge clk) begin
      t0 <= (mode == 1) ? 1'b0 : (mode == 3) ? 1'b1 : (trk == 0);
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         print_verdict();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   // Polls write enable: it only rises once the tests have passed
   task automatic wait_ready();
      int t;
      t = 0;
      u_host_ctrl_model.drive(4'h1 << addr, 1'b1, 1'b0, 1'b0);
      while (we !== 1'b1 && t < 4000) begin
         @(negedge clk);
         t++;
      end
      check("ready", {7'h0, we}, 8'h1);
   endtask
   // Sizes of two flash groups, starting at a long dark gap
   task automatic flashes(output int f0, output int f1);
      int g[3];
      int dark, k, t;
      g = '{0, 0, 0};
      dark = 0;
      k = -1;
      t = 0;
      while (k < 3 && t < 20000) begin
         @(negedge clk);
         t++;
         if (led === 1'b1) begin
            if (dark > 8) k++;
            if (dark > 0 && k >= 0 && k < 3) g[k]++;
            dark = 0;
         end else begin
            dark++;
         end
      end
      f0 = (g[0] == 3) ? g[0] : g[1];
      f1 = (g[0] == 3) ? g[1] : g[2];
   endtask
   initial begin
      addr <= 2'h2;
      wp <= 1'b0;
      i0 <= 1'b0;
      i1 <= 1'b0;
      lev <= 1'b0;
      raw <= 1'b0;
      @(negedge clk);
      check("idle", {wpo, two, t0o, ixo, rdo, hl, we, led}, 8'h0);
      do_reset();
      wait_ready();
      check("max_track", 8'(maxtrk), 8'(IN_STEPS));
      check("end_track", 8'(trk), 8'h0);
      repeat (40) begin
         r = lfsr(r);
         u_host_ctrl_model.drive(r[5:2], r[7], r[8], r[10]);
         addr <= r[1:0];
         wp <= r[6];
         i0 <= r[11];
         raw <= r[12];
         repeat (3) @(posedge clk);
         @(negedge clk);
         check("wprot", wpo, r[r[1:0] + 2] & r[6]);
         check("wen", we, r[r[1:0] + 2] & r[7] & !r[6]);
         check("wdata", wdo, r[r[1:0] + 2] & r[7] & !r[6] & r[8]);
         check("led", led, r[r[1:0] + 2]);
         check("index", ixo, r[r[1:0] + 2] & r[11]);
         check("rdata", rdo, r[r[1:0] + 2] & r[12]);
         check("sides", {hl, two}, 8'h0);
      end
      addr <= 2'h1;
      wp <= 1'b0;
      i0 <= 1'b0;
      u_host_ctrl_model.drive(4'h2, 1'b0, 1'b0, 1'b1);
      repeat (3) u_host_ctrl_model.seek_step(1'b1);
      u_host_ctrl_model.drive(4'h1, 1'b0, 1'b0, 1'b0);
      u_host_ctrl_model.seek_step(1'b0);
      check("step_refused", 8'(trk), 8'h3);
      u_host_ctrl_model.drive(4'h2, 1'b0, 1'b0, 1'b0);
      repeat (3) u_host_ctrl_model.seek_step(1'b0);
      check("track0", {7'h0, t0o}, 8'h1);
      u_host_ctrl_model.drive(4'h0, 1'b0, 1'b0, 1'b0);
      lev <= 1'b1;
      repeat (5) @(negedge clk);
      check("head", {7'h0, hl}, 8'h1);
      repeat (410) @(posedge clk);
      flashes(a, b);
      check("idx_first", 8'(a), 8'h3);
      check("idx_second", 8'(b), 8'(CODE_INDEX));
      lev <= 1'b0;
      repeat (150) @(posedge clk);
      a = 0;
      repeat (100) @(negedge clk) a += (led === 1'b1);
      check("err_done", 8'(a), 8'h0);
      lev <= 1'b1;
      repeat (20) @(posedge clk);
      i0 <= 1'b1;
      i1 <= 1'b1;
      repeat (5) @(posedge clk);
      i0 <= 1'b0;
      i1 <= 1'b0;
      repeat (450) @(posedge clk);
      wait_ready();
      check("two_sided", {7'h0, two}, 8'h1);
      for (int m = 1; m <= 3; m++) begin
         mode = m;
         trk = 0;
         maxtrk = 0;
         do_reset();
         flashes(a, b);
         check("car_first", 8'(a), 8'h3);
         check("car_second", 8'(b), (m == 2) ? 8'(CODE_STEP_OUT) : 8'(CODE_STEP_IN));
      end
      print_verdict();
   end
endmodule
